// [hdl/ubm_modem_pins.v]
// Channel B modem control pins, status inputs and multi-function output
`timescale 1ns/1ps
`default_nettype none
`include "ubm_defines.vh"

// Functional notes
// RULE_01: send request low-active, software output otherwise
// RULE_02: software asserts send request before auto mode
// RULE_03: direction control drives send request pin
// RULE_04: send clear low-active, gates auto transmit
// RULE_05: terminal ready low-active, software set
// RULE_06: set-ready, carrier, ring readable low-active inputs
// RULE_07: two-bit select picks one output function
// RULE_08: user function: pin low when bit3 set
// RULE_09: modem control bit3 clears on reset
// RULE_10: baud function outputs 16x baud clock
// RULE_11: receive-ready function outputs low-active ready
// RULE_12: direction mode: high receive, low transmit
// RULE_13: receive after last stop bit, transmit on load
// RULE_14: select codes 0 user, 1 baud, 2 ready
// RULE_15: status inputs synchronised before software reads
module ubm_modem_pins (
    input wire clk,                           // 20 MHz system clock
    input wire resetn,                        // Asynchronous reset, active low
    input wire ce,                            // Clock enable, freezes state when low
    input wire psel,                          // APB select
    input wire penable,                       // APB enable
    input wire pwrite,                        // APB direction, high for write
    input wire [11:0] paddr,                  // APB byte address
    input wire [31:0] pwdata,                 // APB write data
    output wire pready,                       // APB ready
    output reg [31:0] prdata,                 // APB read data
    output wire pslverr,                      // APB error on unmapped address
    input wire baud_clk_16x,                  // 16x baud clock from the baud generator
    input wire rx_ready,                      // Receive data ready, active high, same clock
    input wire tx_load,                       // Pulse: byte loaded into transmitter
    input wire tx_done,                       // Pulse: last stop bit shifted out
    input wire rx_flow_stop,                  // Auto flow logic wants sender paused
    output wire tx_gate,                      // Transmission allowed by send clear
    input wire chan_b_send_clear_n,           // Clear-to-send pin
    input wire chan_b_set_ready_n,            // Set-ready pin
    input wire chan_b_carrier_detect_n,       // Carrier-detect pin
    input wire chan_b_ring_indicator_n,       // Ring-indicator pin
    output reg chan_b_send_request_n,         // Request-to-send pin
    output reg chan_b_terminal_ready_n,       // Terminal-ready pin
    output reg chan_b_multi_function_out_n    // Multi-function pin
);

    reg [7:0] modem_control_reg;
    reg [7:0] alternate_function_reg;
    reg [7:0] feature_control_reg;
    reg [7:0] enhanced_feature_reg;
    reg tx_busy_reg;
    reg baud_pin_reg;
    wire [4:0] pins_async;
    wire [4:0] pins_sync;
    wire wr_en;
    wire rd_en;
    wire addr_ok;
    wire [1:0] mf_sel;
    wire dir_mode;
    wire auto_rts;
    wire auto_cts;
    wire cts_sync_n;
    wire set_ready_sync_n;
    wire carrier_sync_n;
    wire ring_sync_n;
    wire baud_sync;
    wire hit_mcr;
    wire hit_afr;
    wire hit_feature_control_reg;
    wire hit_efr;
    wire hit_msr;
    wire hit_xmit;
    wire bus_access;
    wire wr_mcr;
    wire wr_afr;
    wire wr_feature_control_reg;
    wire wr_efr;
    reg send_request_next;
    reg mf_next;
    reg [31:0] rd_next;

    // Pins come from outside the clock domain
    assign pins_async = {chan_b_ring_indicator_n, chan_b_carrier_detect_n, chan_b_set_ready_n,
                         chan_b_send_clear_n, baud_clk_16x};

    // RULE_15: synchronise status inputs
    ubm_sync #(
        .W(`UBM_SYNC_W)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .d_in(pins_async),
        .q_out(pins_sync)
    );

    // Named views of the synchroniser lanes; only the second stage is read
    assign baud_sync = pins_sync[`UBM_LANE_BAUD];
    assign cts_sync_n = pins_sync[`UBM_LANE_CTS];
    assign set_ready_sync_n = pins_sync[`UBM_LANE_DSR];
    assign carrier_sync_n = pins_sync[`UBM_LANE_CD];
    assign ring_sync_n = pins_sync[`UBM_LANE_RI];

    // Register selects, shared by write and error decode; the read multiplexer decodes paddr itself
    assign hit_mcr = (paddr == `UBM_OFF_MCR);
    assign hit_afr = (paddr == `UBM_OFF_AFR);
    assign hit_feature_control_reg = (paddr == `UBM_OFF_FEATURE_CONTROL_REG);
    assign hit_efr = (paddr == `UBM_OFF_EFR);
    assign hit_msr = (paddr == `UBM_OFF_MSR);
    assign hit_xmit = (paddr == `UBM_OFF_XMIT);

    // APB decode; the slave always answers in the access cycle
    assign addr_ok = hit_mcr | hit_afr | hit_feature_control_reg | hit_efr | hit_msr | hit_xmit;
    assign bus_access = psel & penable;
    assign pready = 1'b1;
    assign pslverr = bus_access & ~addr_ok;
    assign wr_en = bus_access & pwrite & ce;
    // Capturing in setup keeps prdata a flop output yet valid at the access edge
    assign rd_en = psel & ~penable & ~pwrite & ce;

    // Per-register write strobes
    assign wr_mcr = wr_en & hit_mcr;
    assign wr_afr = wr_en & hit_afr;
    assign wr_feature_control_reg = wr_en & hit_feature_control_reg;
    assign wr_efr = wr_en & hit_efr;

    assign mf_sel = alternate_function_reg[`UBM_AFR_SEL_HI:`UBM_AFR_SEL_LO];
    assign dir_mode = feature_control_reg[`UBM_FEATURE_CONTROL_REG_DIR];
    assign auto_rts = enhanced_feature_reg[`UBM_EFR_ARTS];
    assign auto_cts = enhanced_feature_reg[`UBM_EFR_ACTS];

    // Modem control register; the pins read it directly
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // RULE_09: bit3 clears on reset
            modem_control_reg <= `UBM_MCR_RST;
        end else if (wr_mcr) begin
            modem_control_reg <= pwdata[`UBM_MCR_W-1:0];
        end
    end

    // Alternate function register, holds the pin select
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alternate_function_reg <= `UBM_AFR_RST;
        end else if (wr_afr) begin
            alternate_function_reg <= pwdata[`UBM_AFR_W-1:0];
        end
    end

    // Feature control register, holds the direction mode enable
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            feature_control_reg <= `UBM_FEATURE_CONTROL_REG_RST;
        end else if (wr_feature_control_reg) begin
            feature_control_reg <= pwdata[`UBM_FEATURE_CONTROL_REG_W-1:0];
        end
    end

    // Enhanced feature register; bits above the byte are ignored
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            enhanced_feature_reg <= `UBM_EFR_RST;
        end else if (wr_efr) begin
            enhanced_feature_reg <= pwdata[`UBM_EFR_W-1:0];
        end
    end

    // Transmitter activity for direction control; a load in the done cycle wins
    // A character cut short without a done pulse keeps the line in transmit
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_busy_reg <= 1'b0;
        end else if (ce) begin
            // RULE_13: switch on load and last stop bit
            if (tx_load) begin
                tx_busy_reg <= 1'b1;
            end else if (tx_done) begin
                tx_busy_reg <= 1'b0;
            end
        end
    end

    // The gate sees the pin two cycles late; a character in flight still finishes
    // RULE_04: auto mode gates transmit on send clear
    assign tx_gate = ~auto_cts | ~cts_sync_n;

    // Send request source, direction mode taking priority over auto flow
    // Software cannot override the pin while direction mode is on
    always @* begin
        if (dir_mode) begin
            // RULE_03: pin becomes transceiver direction
            // RULE_12: high receive, low transmit
            send_request_next = ~tx_busy_reg;
        end else if (auto_rts) begin
            // RULE_02: software has asserted the bit first
            send_request_next = ~modem_control_reg[`UBM_MCR_RTS] | rx_flow_stop;
        end else begin
            // RULE_01: plain software output
            send_request_next = ~modem_control_reg[`UBM_MCR_RTS];
        end
    end

    // Multi-function pin selection
    always @* begin
        // RULE_07: one function per select code
        // RULE_14: fixed select encoding
        case (mf_sel)
            `UBM_MF_USER: begin
                // RULE_08: low while bit3 is one
                mf_next = ~modem_control_reg[`UBM_MCR_OP2];
            end
            `UBM_MF_BAUD: begin
                // RULE_10: 16x baud clock
                mf_next = baud_pin_reg;
            end
            `UBM_MF_RXRDY: begin
                // RULE_11: ready shown active low
                mf_next = ~rx_ready;
            end
            default: begin
                // Spare code parks the pin at its inactive level
                mf_next = 1'b1;
            end
        endcase
    end

    // Extra stage on the baud lane; the pin lags the generator by four cycles
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            baud_pin_reg <= 1'b1;
        end else if (ce) begin
            baud_pin_reg <= baud_sync;
        end
    end

    // Send request pin is registered so a mode change never glitches it
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chan_b_send_request_n <= 1'b1;
        end else if (ce) begin
            chan_b_send_request_n <= send_request_next;
        end
    end

    // Terminal ready pin follows its software bit one cycle after a write
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chan_b_terminal_ready_n <= 1'b1;
        end else if (ce) begin
            // RULE_05: terminal ready from software bit
            chan_b_terminal_ready_n <= ~modem_control_reg[`UBM_MCR_DTR];
        end
    end

    // Multi-function pin is registered so a select change never glitches it
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chan_b_multi_function_out_n <= 1'b1;
        end else if (ce) begin
            chan_b_multi_function_out_n <= mf_next;
        end
    end

    // Read multiplexer; unmapped addresses read zero
    always @* begin
        rd_next = 32'h0000_0000;
        case (paddr)
            `UBM_OFF_MCR: rd_next[`UBM_MCR_W-1:0] = modem_control_reg;
            `UBM_OFF_AFR: rd_next[`UBM_AFR_W-1:0] = alternate_function_reg;
            `UBM_OFF_FEATURE_CONTROL_REG: rd_next[`UBM_FEATURE_CONTROL_REG_W-1:0] = feature_control_reg;
            `UBM_OFF_EFR: rd_next[`UBM_EFR_W-1:0] = enhanced_feature_reg;
            `UBM_OFF_MSR: begin
                // Only synchronised copies are shown, never a raw pin
                // RULE_06: status inputs readable, shown active high
                rd_next[`UBM_MSR_CTS] = ~cts_sync_n;
                rd_next[`UBM_MSR_DSR] = ~set_ready_sync_n;
                rd_next[`UBM_MSR_CD] = ~carrier_sync_n;
                rd_next[`UBM_MSR_RI] = ~ring_sync_n;
            end
            `UBM_OFF_XMIT: begin
                rd_next[`UBM_XS_BUSY] = tx_busy_reg;
                rd_next[`UBM_XS_GATE] = tx_gate;
                rd_next[`UBM_XS_DIR] = chan_b_send_request_n;
            end
            default: ;
        endcase
    end

    // Read data registered at the setup edge, so it stands when pready is sampled
    // Unmapped reads load zero, so stale data never leaks out
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= rd_next;
        end
    end

endmodule

`default_nettype wire

// [shared/ubm_defines.vh]
// Constants for the channel B modem pin and multi-function output block
`ifndef UBM_DEFINES_VH
`define UBM_DEFINES_VH

// APB register byte offsets
`define UBM_OFF_MCR       12'h000
`define UBM_OFF_AFR       12'h004
`define UBM_OFF_FEATURE_CONTROL_REG      12'h008
`define UBM_OFF_EFR       12'h00c
`define UBM_OFF_MSR       12'h010
`define UBM_OFF_XMIT      12'h014
`define UBM_ADDR_W        12

// Modem control register fields
`define UBM_MCR_DTR       0
`define UBM_MCR_RTS       1
`define UBM_MCR_OP2       3
`define UBM_MCR_W         8
`define UBM_MCR_RST       8'h00

// Alternate function register select field, bits 2:1
`define UBM_AFR_SEL_HI    2
`define UBM_AFR_SEL_LO    1
`define UBM_AFR_W         8
`define UBM_AFR_RST       8'h00
`define UBM_MF_USER       2'h0
`define UBM_MF_BAUD       2'h1
`define UBM_MF_RXRDY      2'h2

// Feature control register: bit 3 enables half-duplex direction control
`define UBM_FEATURE_CONTROL_REG_DIR      3
`define UBM_FEATURE_CONTROL_REG_W        8
`define UBM_FEATURE_CONTROL_REG_RST      8'h00

// Enhanced feature register: bit 6 auto request-to-send, bit 7 auto clear-to-send
`define UBM_EFR_ARTS      6
`define UBM_EFR_ACTS      7
`define UBM_EFR_W         8
`define UBM_EFR_RST       8'h00

// Modem status register: synchronised active-high views of the four status inputs
`define UBM_MSR_CTS       4
`define UBM_MSR_DSR       5
`define UBM_MSR_RI        6
`define UBM_MSR_CD        7

// Transmit status register bits (read only)
`define UBM_XS_BUSY       0
`define UBM_XS_GATE       1
`define UBM_XS_DIR        2

// Synchroniser width, one lane per pin
`define UBM_SYNC_W        5

// Synchroniser lanes, in the order the pins are packed
`define UBM_LANE_BAUD 0
`define UBM_LANE_CTS 1
`define UBM_LANE_DSR 2
`define UBM_LANE_CD 3
`define UBM_LANE_RI 4

`endif

// [hdl/ubm_sync.v]
// Two flip-flop synchroniser for a bank of pin inputs
`timescale 1ns/1ps
`default_nettype none

module ubm_sync #(
    parameter W = 5
) (
    input wire clk,            // System clock
    input wire resetn,         // Asynchronous reset, active low
    input wire ce,             // Clock enable
    input wire [W-1:0] d_in,   // Asynchronous pin levels
    output wire [W-1:0] q_out  // Synchronised levels
);

    genvar gi;

    // One two-stage chain per bit; stage one feeds only stage two
    generate
        for (gi = 0; gi < W; gi = gi + 1) begin : g_bit
            reg s1_reg;
            reg s2_reg;
            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    s1_reg <= 1'b1;
                    s2_reg <= 1'b1;
                end else if (ce) begin
                    s1_reg <= d_in[gi];
                    s2_reg <= s1_reg;
                end
            end
            assign q_out[gi] = s2_reg;
        end
    endgenerate

endmodule

`default_nettype wire

// [test/ubm_modem_pins_properties.sv]
// Assertions on the channel B modem pins and multi-function output
`timescale 1ns/1ps
`default_nettype none
module ubm_pins_chk (
    input wire clk, // Clock
    input wire resetn, // Reset
    input wire ce, // Clock enable
    input wire psel, // Select
    input wire penable, // Enable
    input wire pwrite, // Write
    input wire [11:0] paddr, // Address
    input wire [31:0] pwdata, // Write data
    input wire pslverr, // Bus error
    input wire baud_clk_16x, // Baud clock
    input wire rx_ready, // Rx ready
    input wire tx_load, // Loaded
    input wire tx_done, // Sent
    input wire rx_flow_stop, // Flow stop
    input wire tx_gate, // Send allowed
    input wire chan_b_send_clear_n, // Clear pin
    input wire chan_b_send_request_n, // Request pin
    input wire chan_b_terminal_ready_n, // Ready pin
    input wire chan_b_multi_function_out_n // Multi pin
);
    logic [7:0] regs_q [4];
    logic busy_q;
    wire [7:0] ctl = regs_q[0];
    wire [1:0] sel = regs_q[1][2:1];
    wire [7:0] feat = regs_q[2];
    wire [7:0] enh = regs_q[3];
    wire srn = chan_b_send_request_n;
    wire mfn = chan_b_multi_function_out_n;
    // Shadow registers; a load in the same cycle as the last stop bit keeps the line busy
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            regs_q <= '{default: 8'h00};
            busy_q <= 1'b0;
        end else if (ce) begin
            if (psel && penable && pwrite && paddr[11:4] == 8'h00) begin
                regs_q[paddr[3:2]] <= pwdata[7:0];
            end
            busy_q <= tx_load || (busy_q && !tx_done);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    rst_idle_a: assert property ($rose(resetn) |-> srn && chan_b_terminal_ready_n && mfn)
        else $error("pins not idle after reset");
    user_pin_a: assert property (sel == 2'h0 && $stable(sel) && $stable(ctl) |-> mfn == !ctl[3])
        else $error("user output level wrong");
    term_pin_a: assert property ($stable(ctl) |-> chan_b_terminal_ready_n == !ctl[0])
        else $error("terminal ready level wrong");
    req_pin_a: assert property (!feat[3] && $stable(feat) && $stable(ctl) && $stable(enh) && $stable(rx_flow_stop)
        |-> srn == (!ctl[1] || (enh[6] && rx_flow_stop))) else $error("send request level wrong");
    dir_pin_a: assert property (feat[3] && $stable(feat) && $stable(busy_q) |-> srn == !busy_q)
        else $error("direction level wrong");
    rdy_pin_a: assert property (sel == 2'h2 && $stable(sel) && $stable(rx_ready) |-> mfn == !rx_ready)
        else $error("receive ready level wrong");
    baud_pin_a: assert property ((sel == 2'h1) [*5] |-> (mfn ^ $past(mfn)) ==
        ($past(baud_clk_16x, 4) ^ $past(baud_clk_16x, 5))) else $error("baud clock not passed");
    gate_flow_a: assert property ((enh[7] && $stable(chan_b_send_clear_n)) [*4]
        |-> tx_gate == !chan_b_send_clear_n) else $error("send gate wrong");
    err_resp_a: assert property (psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h014))
        else $error("bus error wrong");
endmodule
bind ubm_modem_pins ubm_pins_chk ubm_pins_chk_i (.clk, .resetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pslverr, .baud_clk_16x, .rx_ready, .tx_load, .tx_done, .rx_flow_stop, .tx_gate, .chan_b_send_clear_n,
    .chan_b_send_request_n, .chan_b_terminal_ready_n, .chan_b_multi_function_out_n);
`default_nettype wire

// [test/ubm_modem_model.sv]
// Behavioural modem that drives the channel B status pins
`timescale 1ns/1ps
`default_nettype none
module ubm_modem_model (
    input wire logic clk, // Clock
    input wire logic slow, // Answer two cycles late
    input wire logic [3:0] want, // Asserted: clear, set ready, carrier, ring
    output logic [3:0] pins_n // Same order, active low
);
    logic [3:0] d1_q, d2_q;
    initial pins_n = 4'hf;
    // A slow modem lags its changes; pins stay active low either way
    always @(posedge clk) begin
        d1_q <= want;
        d2_q <= d1_q;
        pins_n <= ~(slow ? d2_q : want);
    end
endmodule
`default_nettype wire

// [test/tb_uart_b_modem_pins_mux.sv]
// Self-checking bench for the channel B modem pins and multi-function output
`timescale 1ns/1ps
`default_nettype none
`include "ubm_defines.vh"
module tb_uart_b_modem_pins_mux;
    logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, err, p1, slow = 0, ce = 1;
    logic baud = 0, rxr = 0, load = 0, done = 0, flow = 0, pready, pslverr, gate, srn, dtrn, mfn;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] want = 4'h0, pins_n;
    int n_errors = 0, num_checks = 0, cyc = 0;
    ubm_modem_pins ubm_modem_pins_i (.clk, .resetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .baud_clk_16x(baud), .rx_ready(rxr), .tx_load(load), .tx_done(done),
        .rx_flow_stop(flow), .tx_gate(gate), .chan_b_send_clear_n(pins_n[0]), .chan_b_set_ready_n(pins_n[1]),
        .chan_b_carrier_detect_n(pins_n[2]), .chan_b_ring_indicator_n(pins_n[3]),
        .chan_b_send_request_n(srn), .chan_b_terminal_ready_n(dtrn), .chan_b_multi_function_out_n(mfn));
    ubm_modem_model ubm_modem_model_i (.clk, .slow, .want, .pins_n);
    // 20 MHz clock
    always #25 clk = ~clk;
    // Hang guard, far above the run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            test_done;
        end
    end
    task test_done;
        if (n_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer; response and read data are taken at the edge that samples pready high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Compares request, terminal ready and multi-function levels once settled
    task pins(input logic [2:0] exp);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(32'({srn, dtrn, mfn}), 32'(exp));
    endtask
    task t_reset;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            chk(rd, 32'h0);
        end
        pins(3'b111);
    endtask
    // Clock enable low freezes the registers, so a write then is lost
    task t_hold;
        @(posedge clk) ce <= 1'b0;
        apb(1'b1, `UBM_OFF_MCR, 32'h1);
        @(posedge clk) ce <= 1'b1;
        apb(1'b0, `UBM_OFF_MCR, 32'h0);
        chk(rd, 32'h0);
        pins(3'b111);
    endtask
    task t_ctl;
        logic [7:0] v [3] = '{8'h0b, 8'h03, 8'h08};
        logic [2:0] e [3] = '{3'b000, 3'b001, 3'b110};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `UBM_OFF_MCR, {24'hffffff, v[i]});
            pins(e[i]);
        end
    endtask
    task t_status;
        logic [3:0] w;
        for (int i = 0; i < 5; i++) begin
            w = (i == 4) ? 4'hf : 4'(1 << i);
            @(posedge clk) want <= w;
            slow <= i[0];
            repeat (6) @(posedge clk);
            apb(1'b0, `UBM_OFF_MSR, 32'h0);
            chk(rd & 32'hf0, 32'({w[2], w[3], w[1], w[0], 4'h0}));
        end
        slow <= 1'b0;
    endtask
    task t_mux;
        apb(1'b1, `UBM_OFF_AFR, 32'({`UBM_MF_BAUD, 1'b0}));
        @(posedge clk) baud <= 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk) p1 = mfn;
        @(posedge clk) baud <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk(32'(p1 ^ mfn), 32'h1);
        apb(1'b1, `UBM_OFF_AFR, 32'({`UBM_MF_RXRDY, 1'b0}));
        @(posedge clk) rxr <= 1'b1;
        pins(3'b110);
        @(posedge clk) rxr <= 1'b0;
        pins(3'b111);
        apb(1'b1, `UBM_OFF_AFR, 32'h6);
        pins(3'b111);
        apb(1'b1, `UBM_OFF_AFR, 32'h0);
        pins(3'b110);
    endtask
    task t_auto;
        apb(1'b1, `UBM_OFF_MCR, 32'h2);
        apb(1'b1, `UBM_OFF_EFR, 32'hc0);
        @(posedge clk) flow <= 1'b1;
        pins(3'b111);
        @(posedge clk) flow <= 1'b0;
        pins(3'b011);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk) want <= 4'(i);
            repeat (6) @(posedge clk);
            @(negedge clk);
            chk(32'(gate), 32'(i));
        end
        apb(1'b1, `UBM_OFF_EFR, 32'h0);
    endtask
    task t_dir;
        apb(1'b1, `UBM_OFF_FEATURE_CONTROL_REG, 32'h8);
        pins(3'b111);
        @(posedge clk) load <= 1'b1;
        @(posedge clk) load <= 1'b0;
        pins(3'b011);
        apb(1'b0, `UBM_OFF_XMIT, 32'h0);
        chk(rd & 32'h5, 32'h1);
        @(posedge clk) done <= 1'b1;
        @(posedge clk) done <= 1'b0;
        pins(3'b111);
        @(posedge clk) begin
            load <= 1'b1;
            done <= 1'b1;
        end
        @(posedge clk) begin
            load <= 1'b0;
            done <= 1'b0;
        end
        pins(3'b011);
    endtask
    task t_err;
        apb(1'b1, 12'h020, 32'hff);
        chk(32'(err), 32'h1);
        apb(1'b0, 12'h020, 32'h0);
        chk({rd[30:0], err}, 32'h1);
    endtask
    // Second reset in mid-run, with the user output bit set beforehand
    task t_again;
        apb(1'b1, `UBM_OFF_MCR, 32'h8);
        @(posedge clk) resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        t_reset;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        t_reset;
        t_hold;
        t_ctl;
        t_status;
        t_mux;
        t_auto;
        t_dir;
        t_err;
        t_again;
        test_done;
    end
endmodule
`default_nettype wire
